// ---- hw/ddsc_map.svh ----
// constants for one synthesizer channel: widths, field positions, reset values
`ifndef DDSC_MAP_SVH
`define DDSC_MAP_SVH
`define DDSC_ACC_W 32
`define DDSC_SAMPLE_W 12
`define DDSC_CODE_W 3
`define DDSC_CODE_LSB 29
`define DDSC_HI_MSB 31
`define DDSC_HI_LSB 24
`define DDSC_LO_MSB 23
`define DDSC_PHASE_LSB 20
`define DDSC_HALF_MSB 10
`define DDSC_HALF_ONE 12'h800
`define DDSC_SINE_SHIFT 9
`define DDSC_SINE_MAX 11'h7FF
`define DDSC_FIFO_DEPTH 32
`define DDSC_PAD_DEPTH 23
`define DDSC_ACC_RESET 32'h0000_0000
`define DDSC_SAMPLE_RESET 12'h000
`endif

// ---- hw/ddsc_pkg.sv ----
// types shared by the channel, its checks and its bench
package ddsc_pkg;
   // settings written by the processor, pending or active copy
   typedef struct packed {
      logic [31:0] increment_a;
      logic [31:0] increment_b;
      logic hop_phase_enable;
      logic pin_phase_enable;
      logic pin_select_enable;
      logic partial_add_enable;
      logic twos_complement;
   } ddsc_cfg_t;
   // one coded sample heading for the dac
   typedef struct packed {
      logic [11:0] data;
   } ddsc_sample_t;
endpackage : ddsc_pkg

// ---- hw/ddsc_fifo.sv ----
// sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module ddsc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic do_wr;
   logic do_rd;
   // extra pointer bit tells full from empty
   assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   // storage carries no reset, pointers guard it
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
      end else if (do_wr) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= '0;
      end else if (do_rd) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : ddsc_fifo

// ---- hw/ddsc_channel.sv ----
// one synthesizer channel: increment select, hop activation, phase offset, sine output
`timescale 1ns/1ps
`include "ddsc_map.svh"
module ddsc_channel import ddsc_pkg::*; #(
   parameter int PAD_DEPTH = `DDSC_PAD_DEPTH,
   parameter int FIFO_DEPTH = `DDSC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire ddsc_cfg_t pending_cfg,
   input wire logic hop_strobe,
   input wire logic freq_select_in,
   input wire logic freq_select_latch,
   input wire logic [2:0] phase_code_in,
   input wire logic phase_code_latch,
   input wire logic sample_ready,
   output logic [11:0] sample_out,
   output logic sample_strobe,
   output logic hop_pending,
   output logic freq_select_active,
   output logic [2:0] phase_code_active
);
   // every asynchronous pin passes three flops; stage 1 feeds stage 2 only
   logic [2:0] hop_sync;
   logic [2:0] fsl_sync;
   logic [2:0] fsi_sync;
   logic [2:0] pcl_sync;
   logic [2:0] pci_s1;
   logic [2:0] pci_s2;
   logic [2:0] pci_s3;
   logic hop_rise;
   logic fsl_rise;
   logic pcl_rise;
   ddsc_cfg_t active_cfg;
   logic one_shot;
   logic freq_select;
   logic [2:0] phase_code;
   logic [31:0] acc;
   logic [31:0] next_inc;
   logic [7:0] hi_sum;
   logic [31:0] phase;
   logic [11:0] raw_sample;
   logic [11:0] pad [PAD_DEPTH];
   logic [PAD_DEPTH-1:0] pad_valid;
   logic run;
   logic fifo_in_ready;
   ddsc_sample_t fifo_out;
   logic fifo_out_valid;
   logic fifo_pop;

   // synchronisers for strobes and their data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hop_sync <= 3'h0;
         fsl_sync <= 3'h0;
         fsi_sync <= 3'h0;
         pcl_sync <= 3'h0;
      end else begin
         hop_sync <= {hop_sync[1:0], hop_strobe};
         fsl_sync <= {fsl_sync[1:0], freq_select_latch};
         fsi_sync <= {fsi_sync[1:0], freq_select_in};
         pcl_sync <= {pcl_sync[1:0], phase_code_latch};
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pci_s1 <= 3'h0;
         pci_s2 <= 3'h0;
         pci_s3 <= 3'h0;
      end else begin
         pci_s1 <= phase_code_in;
         pci_s2 <= pci_s1;
         pci_s3 <= pci_s2;
      end
   end
   // a rise counts once stages two and three disagree upward
   assign hop_rise = hop_sync[1] && !hop_sync[2];
   assign fsl_rise = fsl_sync[1] && !fsl_sync[2];
   assign pcl_rise = pcl_sync[1] && !pcl_sync[2];

   // pending_cfg stands for the processor-written registers
   // each channel instance has its own clock, strobes and settings
   // hop strobe moves pending settings into the active copy
   // the processor keeps its own pending copy, so hop_phase_enable stays set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_cfg <= '0;
      end else if (hop_rise) begin
         active_cfg <= pending_cfg;
      end
   end

   // one-shot arms on each hop while hop phase enable is pending
   // consumed on the first accumulation that runs; a new hop re-arms (set wins)
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         one_shot <= 1'b0;
      end else if (hop_rise) begin
         one_shot <= pending_cfg.hop_phase_enable;
      end else if (run) begin
         one_shot <= 1'b0;
      end
   end

   // frequency select captured on the latch rise, synchronised data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_select <= 1'b0;
      end else if (fsl_rise) begin
         freq_select <= fsi_sync[2];
      end
   end

   // phase code captured only while pin phase enable is active
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_code <= 3'h0;
      end else if (pcl_rise && active_cfg.pin_phase_enable) begin
         phase_code <= pci_s3;
      end
   end

   // increment choice; upper bytes wrap in the partial add
   assign hi_sum = 8'(active_cfg.increment_a[`DDSC_HI_MSB:`DDSC_HI_LSB]
                 + active_cfg.increment_b[`DDSC_HI_MSB:`DDSC_HI_LSB]);
   always_comb begin
      next_inc = active_cfg.increment_a;
      if (one_shot) begin
         if (active_cfg.partial_add_enable) begin
            next_inc = {hi_sum, active_cfg.increment_a[`DDSC_LO_MSB:0]};
         end else begin
            next_inc = active_cfg.increment_b;
         end
      end else if (active_cfg.pin_phase_enable) begin
         next_inc = active_cfg.increment_a;
      end else if (active_cfg.pin_select_enable && freq_select) begin
         next_inc = active_cfg.increment_b;
      end
   end

   // accumulator never reloads on a switch, so frequency steps are phase continuous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= `DDSC_ACC_RESET;
      end else if (run) begin
         acc <= acc + next_inc;
      end
   end

   // code times 45 degrees lands on the top three phase bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= `DDSC_ACC_RESET;
      end else if (run) begin
         phase <= acc + {phase_code, {`DDSC_CODE_LSB{1'b0}}};
      end
   end

   // parabolic sine: half wave 4x(1-x), sign from top phase bit
   // trades a lookup table for a few percent of shape error
   function automatic logic [11:0] sine_of(input logic [11:0] p, input logic twos);
      logic [10:0] x;
      logic [21:0] prod;
      logic [10:0] mag;
      logic [11:0] s;
      x = p[`DDSC_HALF_MSB:0];
      prod = 22'(x) * 22'(12'h800 - 12'(x));
      mag = (prod[21:`DDSC_SINE_SHIFT] > 13'(`DDSC_SINE_MAX)) ? `DDSC_SINE_MAX
            : prod[19:`DDSC_SINE_SHIFT];
      s = p[11] ? 12'(-{1'b0, mag}) : {1'b0, mag};
      // offset binary flips the sign bit of two's complement
      sine_of = twos ? s : (s ^ `DDSC_HALF_ONE);
   endfunction : sine_of

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_sample <= `DDSC_SAMPLE_RESET;
      end else if (run) begin
         raw_sample <= sine_of(phase[`DDSC_ACC_W-1:`DDSC_PHASE_LSB], active_cfg.twos_complement);
      end
   end

   // padding line sets the hop-to-output delay
   always_ff @(posedge clk) begin
      if (run) begin
         pad[0] <= raw_sample;
         for (int i = 1; i < PAD_DEPTH; i++) begin
            pad[i] <= pad[i-1];
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_valid <= '0;
      end else if (run) begin
         pad_valid <= {pad_valid[PAD_DEPTH-2:0], 1'b1};
      end
   end

   // a full fifo stalls the whole pipeline, so no sample is lost
   assign run = fifo_in_ready;

   ddsc_fifo #(
      .WIDTH(`DDSC_SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(pad[PAD_DEPTH-1]),
      .in_valid(pad_valid[PAD_DEPTH-1]),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );
   assign fifo_pop = fifo_out_valid && sample_ready;

   // one sample and one strobe per clock while the dac takes them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_out <= `DDSC_SAMPLE_RESET;
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= fifo_pop;
         if (fifo_pop) begin
            sample_out <= fifo_out.data;
         end
      end
   end

   // status mirrors, registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hop_pending <= 1'b0;
         freq_select_active <= 1'b0;
         phase_code_active <= 3'h0;
      end else begin
         hop_pending <= one_shot;
         freq_select_active <= freq_select;
         phase_code_active <= phase_code;
      end
   end
endmodule : ddsc_channel

// ---- bench/ddsc_channel_assertions.sv ----
// port-level checks for one synthesizer channel
`timescale 1ns/1ps
module ddsc_channel_assertions import ddsc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hop_strobe,
   input wire logic freq_select_latch,
   input wire logic phase_code_latch,
   input wire logic sample_ready,
   input wire logic [11:0] sample_out,
   input wire logic sample_strobe,
   input wire logic hop_pending,
   input wire logic freq_select_active,
   input wire logic [2:0] phase_code_active
);
   logic [2:0] seen;
   logic [3:0] hop_age, sel_age, code_age;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // cycles since each strobe pin went high, saturating so long gaps stay legal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen <= 3'h0;
         hop_age <= 4'hF;
         sel_age <= 4'hF;
         code_age <= 4'hF;
      end else begin
         seen <= {hop_strobe, freq_select_latch, phase_code_latch};
         hop_age <= (hop_strobe && !seen[2]) ? 4'h0 : hop_age + {3'h0, hop_age != 4'hF};
         sel_age <= (freq_select_latch && !seen[1]) ? 4'h0 : sel_age + {3'h0, sel_age != 4'hF};
         code_age <= (phase_code_latch && !seen[0]) ? 4'h0 : code_age + {3'h0, code_age != 4'hF};
      end
   end
   sequence ready_run;
      sample_ready [*4];
   endsequence
   strobe_cause_a: assert property (sample_strobe |-> $past(sample_ready))
      else $error("strobe without ready");
   strobe_stream_a: assert property (sample_strobe && sample_ready |=> sample_strobe)
      else $error("sample stream gap");
   sample_hold_a: assert property ($changed(sample_out) |-> sample_strobe)
      else $error("sample moved unstrobed");
   reset_quiet_a: assert property ($rose(rst_n) |-> !sample_strobe && !hop_pending && sample_out == 12'h000)
      else $error("outputs live after reset");
   hop_cause_a: assert property ($rose(hop_pending) |-> hop_age <= 4'h7)
      else $error("one-shot armed without hop");
   hop_once_a: assert property ($rose(hop_pending) ##0 ready_run |-> !hop_pending)
      else $error("one-shot lingers");
   select_cause_a: assert property ($changed(freq_select_active) |-> sel_age <= 4'h7)
      else $error("select moved without latch");
   code_cause_a: assert property ($changed(phase_code_active) |-> code_age <= 4'h7)
      else $error("code moved without latch");
endmodule : ddsc_channel_assertions

bind ddsc_channel ddsc_channel_assertions chk_u (.clk(clk), .rst_n(rst_n), .hop_strobe(hop_strobe),
   .freq_select_latch(freq_select_latch), .phase_code_latch(phase_code_latch), .sample_ready(sample_ready),
   .sample_out(sample_out), .sample_strobe(sample_strobe), .hop_pending(hop_pending),
   .freq_select_active(freq_select_active), .phase_code_active(phase_code_active));

// ---- bench/ddsc_dac_model.sv ----
// dac stand-in: ready follows the bench's stall request
`timescale 1ns/1ps
module ddsc_dac_model (
   input wire logic clk,
   input wire logic stall,
   output logic sample_ready
);
   // ready follows the stall request directly; the bench moves stall on the falling edge,
   // so the channel sees a settled level and no sample slips out after a stall is asked for
   always_comb sample_ready = !stall;
endmodule : ddsc_dac_model

// ---- bench/test_dds_channel_modulation_control.sv ----
// channel bench: settings, hops and latched pins in, samples checked against the sine shape
`timescale 1ns/1ps
module test_dds_channel_modulation_control import ddsc_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ddsc_cfg_t pending_cfg = '0;
   ddsc_cfg_t cfg;
   logic hop_strobe = 1'b0;
   logic freq_select_in = 1'b0;
   logic freq_select_latch = 1'b0;
   logic [2:0] phase_code_in = 3'h0;
   logic phase_code_latch = 1'b0;
   logic stall = 1'b0;
   logic sample_ready, sample_strobe, hop_pending, freq_select_active;
   logic [11:0] sample_out, s, p;
   logic [2:0] phase_code_active;
   int miscompares, check_count, delay;

   always #20 clk = ~clk;

   ddsc_channel dut_u (.clk(clk), .rst_n(rst_n), .pending_cfg(pending_cfg), .hop_strobe(hop_strobe),
      .freq_select_in(freq_select_in), .freq_select_latch(freq_select_latch), .phase_code_in(phase_code_in),
      .phase_code_latch(phase_code_latch), .sample_ready(sample_ready), .sample_out(sample_out),
      .sample_strobe(sample_strobe), .hop_pending(hop_pending), .freq_select_active(freq_select_active),
      .phase_code_active(phase_code_active));
   ddsc_dac_model dac_u (.clk(clk), .stall(stall), .sample_ready(sample_ready));

   task check(input string name, input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check

   // half-wave parabola, negated when the top phase bit is set
   function automatic logic [11:0] sine(input logic [31:0] ph);
      logic [21:0] m;
      m = (22'(ph[30:20]) * (22'd2048 - 22'(ph[30:20]))) >> 9;
      m = (m > 22'd2047) ? 22'd2047 : m;
      return ph[31] ? -m[11:0] : m[11:0];
   endfunction : sine

   task reset;
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
   endtask : reset

   // next strobed sample; each call moves at least one cycle on
   task get;
      repeat (200) begin
         @(negedge clk);
         if (sample_strobe) break;
      end
      s = sample_out;
   endtask : get

   // one-clock hop pulse, then a quiet spell well over the minimum spacing
   task hop(input ddsc_cfg_t c);
      logic [11:0] s0;
      logic moved;
      pending_cfg = c;
      s0 = sample_out;
      moved = 1'b0;
      delay = 0;
      hop_strobe = 1'b1;
      repeat (60) begin
         @(negedge clk);
         hop_strobe = 1'b0;
         delay += !moved;
         moved |= (sample_out !== s0);
      end
   endtask : hop

   // data set up first, latches held three clocks
   task latch(input logic sel, input logic [2:0] code);
      freq_select_in = sel;
      phase_code_in = code;
      @(negedge clk);
      {freq_select_latch, phase_code_latch} = 2'b11;
      repeat (3) @(negedge clk);
      {freq_select_latch, phase_code_latch} = 2'b00;
      repeat (40) @(negedge clk);
   endtask : latch

   task results;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   initial begin
      reset;
      cfg = '0;
      for (int t = 0; t < 2; t++) begin
         cfg.twos_complement = t[0];
         hop(cfg);
         get;
         check("basic", s, t ? 12'h000 : 12'h800);
      end
      $display("basic done");
      cfg.increment_b = 32'h2000_0000;
      hop(cfg);
      latch(1'b1, 3'h5);
      get;
      check("sel off", s, 12'h000);
      check("sel latched", 12'(freq_select_active), 12'h001);
      check("code off", 12'(phase_code_active), 12'h000);
      cfg.pin_select_enable = 1'b1;
      hop(cfg);
      // lock onto the unique peak, then follow 45 degree steps through a full-fifo stall
      repeat (20) begin
         get;
         if (s === 12'h7FF) break;
      end
      for (int i = 3; i < 43; i++) begin
         if (i == 13) begin
            stall = 1'b1;
            repeat (40) @(negedge clk);
            stall = 1'b0;
         end
         get;
         check("step", s, sine(32'(i) * 32'h2000_0000));
      end
      latch(1'b0, 3'h0);
      check("sel cleared", 12'(freq_select_active), 12'h000);
      // the fifo stays nearly full after the stall, so the switch shows up a fifo depth later
      repeat (40) @(negedge clk);
      get;
      p = s;
      get;
      check("held", s, p);
      $display("select done");
      reset;
      cfg = '0;
      cfg.twos_complement = 1'b1;
      cfg.pin_phase_enable = 1'b1;
      cfg.pin_select_enable = 1'b1;
      cfg.increment_b = 32'h0123_4567;
      hop(cfg);
      for (int c = 0; c < 8; c++) begin
         latch(1'b1, 3'(c));
         get;
         check("code", s, sine({3'(c), 29'h0}));
         check("code latched", 12'(phase_code_active), 12'(c));
      end
      $display("phase done");
      reset;
      cfg = '0;
      cfg.twos_complement = 1'b1;
      hop(cfg);
      cfg.hop_phase_enable = 1'b1;
      cfg.partial_add_enable = 1'b1;
      cfg.increment_b = 32'h20FF_FFFF;
      hop(cfg);
      check("hop delay", 12'(delay >= 29 && delay <= 32), 12'h001);
      get;
      p = s;
      get;
      check("partial", p, 12'h600);
      check("once", s, 12'h600);
      cfg.partial_add_enable = 1'b0;
      cfg.increment_b = 32'h2000_0000;
      hop(cfg);
      get;
      check("full", s, 12'h7FF);
      $display("hop done");
      results;
   end

   // hang guard, several times the expected run
   initial begin
      #400000;
      miscompares++;
      results;
   end
endmodule : test_dds_channel_modulation_control
